// file: mscs_consts.svh
// Offsets, field positions, reset values and fixed figures.
// Assumes inclusion by bare name from the engine and bench files.
`ifndef MSCS_CONSTS_SVH
`define MSCS_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define MSCS_OFF_CTRL 8'h00
`define MSCS_OFF_STATUS 8'h04
`define MSCS_OFF_ABASE 8'h08
`define MSCS_OFF_ALEN 8'h0C
`define MSCS_OFF_BBASE 8'h10
`define MSCS_OFF_BLEN 8'h14
`define MSCS_OFF_CBASE 8'h18
`define MSCS_OFF_IDXA 8'h1C
`define MSCS_OFF_IDXB 8'h20
`define MSCS_OFF_THRLO 8'h24
`define MSCS_OFF_THRHI 8'h28
`define MSCS_OFF_DFLO 8'h2C
`define MSCS_OFF_DFHI 8'h30

// ****************************************
// Control fields and illegal operation code
// ****************************************
`define MSCS_CTRL_START 0
`define MSCS_CTRL_OP 1
`define MSCS_CTRL_LT 3
`define MSCS_CTRL_NOINC_A 5
`define MSCS_CTRL_NOINC_B 6
`define MSCS_CTRL_MASK_OFF 7
`define MSCS_OP_ILLEGAL 2'h3

// ****************************************
// Data flag bits
// ****************************************
`define MSCS_DF_NOSEL 37
`define MSCS_DF_EQ 53
`define MSCS_DF_GT 54
`define MSCS_DF_LT 55
`define MSCS_RES_EQ 3'h1
`define MSCS_RES_GT 3'h2
`define MSCS_RES_LT 3'h4

// ****************************************
// Data figures
// ****************************************
`define MSCS_BLANK 8'h20
`define MSCS_WORD_SHIFT 2'h3
`define MSCS_BYTE_SHIFT 2'h0
`define MSCS_ONES 64'hFFFF_FFFF_FFFF_FFFF
`define MSCS_RST_WORD 32'h0000_0000

`endif

// file: mscs_pkg.sv
// Types shared by the compare and search engine and its bench.
// Assumes mscs_consts.svh is on the include path.
package mscs_pkg;

  // ****************************************
  // Enumerations
  // ****************************************
  typedef enum logic [4:0] {
    st_idle = 5'h01,
    st_rd_a = 5'h02,
    st_rd_b = 5'h04,
    st_rd_c = 5'h08,
    st_eval = 5'h10
  } mscs_fsm_t;

  typedef enum logic [1:0] {
    op_masked_field_compare = 2'h0,
    op_masked_key_search_byte = 2'h1,
    op_masked_key_search_word = 2'h2
  } mscs_op_t;

  typedef enum logic [1:0] {
    lt_length = 2'h0,
    lt_delim8 = 2'h1,
    lt_delim16 = 2'h2
  } mscs_lt_t;

  // ****************************************
  // Whole state of the engine
  // ****************************************
  typedef struct packed {
    mscs_fsm_t st;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic req;
    logic [31:0] addr;
    mscs_op_t op;
    mscs_lt_t lt;
    logic noinc_a;
    logic noinc_b;
    logic mask_off;
    logic [31:0] abase;
    logic [31:0] alen;
    logic [31:0] bbase;
    logic [31:0] blen;
    logic [31:0] cbase;
    logic [31:0] idx_a;
    logic [31:0] idx_b;
    logic [47:0] thr;
    logic [63:0] dflag;
    logic [31:0] cnt;
    logic [31:0] k;
    logic [31:0] a0;
    logic [31:0] b0;
    logic [47:0] diff;
    logic [63:0] ra;
    logic [63:0] rb;
    logic [63:0] rc;
    logic [7:0] pa;
    logic [7:0] pb;
    logic a_end;
    logic b_end;
    logic scan;
    logic done;
    logic fin;
  } mscs_regs_t;

endpackage

// file: mscs_cmp_if.sv
// Operand and result wires between engine and compare unit.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface mscs_cmp_if;
  logic [63:0] a;
  logic [63:0] b;
  logic [63:0] m;
  logic neq;
  logic gt;
  modport src (output a, output b, output m, input neq, input gt);
  modport unit (input a, input b, input m, output neq, output gt);
endinterface

// file: mscs_cmp.sv
// Masked compare of two operands, unsigned ordering.
// Assumes unused upper operand bits are zero.
`timescale 1ns/1ps
module mscs_cmp (
  // Operands and results
  mscs_cmp_if.unit cif
);
  // ****************************************
  // Masked compare
  // ****************************************
  assign cif.neq = |((cif.a ^ cif.b) & cif.m);
  assign cif.gt = (cif.a & cif.m) > (cif.b & cif.m);
endmodule

// file: mscs_engine.sv
// Masked field compare and masked key search engine with APB registers.
// Assumes a same-clock memory read port returning the addressed byte
// in the low bits, or the whole word in word mode.
//
// What this block does
// - Unequal end advances enabled source indexes by compares done before it.
// - Both fields exhausted means equal; enabled indexes advance by lengths.
// - Delimited fields are scanned so each index reaches the next field.
// - One length type governs both source fields.
// - Control bits 5 and 6 freeze source indexes in compare only; search always moves the first index; mask index never moves.
// - Compare sets exactly one of flags 53, 54, 55 before ending.
// - Search compares key bytes in order; whole key within limit matches.
// - Failed attempt restarts key one byte further along the reference.
// - At most reference minus key plus one attempts; none sets flag 37.
// - Reference index grows per failed attempt, or by full length.
// - Zero mask bits always match; mask aligns with the key.
// - Search mask designator zero uses an all-ones mask.
// - Threshold comes from a 48-bit value, positive only meaningful.
// - Attempt fails only past threshold differences; count restarts each.
// - Shorter length-type field padded with blanks; stop on inequality, end, delimiter.
// - Compare without mask field uses ones until termination.
// - Word search compares masked words, counts and steps in words.
`timescale 1ns/1ps
`include "mscs_consts.svh"
module mscs_engine (
  // Clock and reset
  input logic clk,
  input logic rstn,
  // APB slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Memory read port
  output logic mem_req,
  output logic [31:0] mem_addr,
  input logic [63:0] mem_rdata,
  input logic mem_ack
);
  import mscs_pkg::*;

  localparam mscs_regs_t rst_v = '{st: st_idle, op: op_masked_field_compare,
    lt: lt_length, default: '0};

  mscs_regs_t q;
  mscs_regs_t d;
  mscs_cmp_if cif ();
  logic srch;
  logic word;
  logic [1:0] sh;
  logic [63:0] opa;
  logic [63:0] opb;
  logic [63:0] opm;

  // ****************************************
  // Operand steering
  // ****************************************
  assign srch = q.op != op_masked_field_compare;
  assign word = q.op == op_masked_key_search_word;
  assign sh = word ? `MSCS_WORD_SHIFT : `MSCS_BYTE_SHIFT;
  assign opa = word ? q.ra : {56'h0, q.ra[7:0]};
  assign opb = word ? q.rb : {56'h0, q.rb[7:0]};
  assign opm = q.mask_off ? `MSCS_ONES :
    (word ? q.rc : {56'h0, q.rc[7:0]});
  assign cif.a = opa;
  assign cif.b = opb;
  assign cif.m = opm;

  mscs_cmp u_cmp (
    .cif (cif.unit)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic wr;
    logic a_done;
    logic b_done;
    logic del_a;
    logic del_b;
    logic [47:0] diffn;
    logic [31:0] a_addr;
    logic [31:0] b_addr;
    logic [31:0] c_addr;
    wr = psel & penable & pwrite & q.pready & ~q.pslverr;
    a_done = q.a_end | (~srch & q.lt == lt_length & q.cnt >= q.alen);
    b_done = q.b_end | (~srch & q.lt == lt_length & q.cnt >= q.blen);
    del_a = 1'b0;
    del_b = 1'b0;
    diffn = q.diff + {47'h0, cif.neq};
    a_addr = q.abase + ((q.a0 + q.k + q.cnt) << sh);
    b_addr = q.bbase + ((q.b0 + q.cnt) << sh);
    c_addr = q.cbase + (q.cnt << sh);
    d = q;
    d.fin = 1'b0;
    d.pready = psel & penable & ~q.pready;
    if (psel & penable & ~q.pready) begin
      d.pslverr = 1'b0;
      unique case (paddr[7:0])
        `MSCS_OFF_CTRL: d.prdata = {24'h0, q.mask_off, q.noinc_b, q.noinc_a,
          q.lt, q.op, 1'b0};
        `MSCS_OFF_STATUS: d.prdata = {30'h0, q.done, q.st != st_idle};
        `MSCS_OFF_ABASE: d.prdata = q.abase;
        `MSCS_OFF_ALEN: d.prdata = q.alen;
        `MSCS_OFF_BBASE: d.prdata = q.bbase;
        `MSCS_OFF_BLEN: d.prdata = q.blen;
        `MSCS_OFF_CBASE: d.prdata = q.cbase;
        `MSCS_OFF_IDXA: d.prdata = q.idx_a;
        `MSCS_OFF_IDXB: d.prdata = q.idx_b;
        `MSCS_OFF_THRLO: d.prdata = q.thr[31:0];
        `MSCS_OFF_THRHI: d.prdata = {16'h0, q.thr[47:32]};
        `MSCS_OFF_DFLO: d.prdata = q.dflag[31:0];
        `MSCS_OFF_DFHI: d.prdata = q.dflag[63:32];
        default: begin
          d.prdata = `MSCS_RST_WORD;
          d.pslverr = 1'b1;
        end
      endcase
    end else begin
      d.prdata = `MSCS_RST_WORD;
      d.pslverr = 1'b0;
    end
    if (wr) begin
      unique case (paddr[7:0])
        `MSCS_OFF_CTRL: begin
          if (q.st == st_idle) begin
            d.op = mscs_op_t'(pwdata[`MSCS_CTRL_OP +: 2]);
            d.lt = mscs_lt_t'(pwdata[`MSCS_CTRL_LT +: 2]);
            d.noinc_a = pwdata[`MSCS_CTRL_NOINC_A];
            d.noinc_b = pwdata[`MSCS_CTRL_NOINC_B];
            d.mask_off = pwdata[`MSCS_CTRL_MASK_OFF];
            if (pwdata[`MSCS_CTRL_START] &&
                pwdata[`MSCS_CTRL_OP +: 2] != `MSCS_OP_ILLEGAL) begin
              d.st = st_rd_a;
              d.a0 = q.idx_a;
              d.b0 = q.idx_b;
              d.cnt = `MSCS_RST_WORD;
              d.k = `MSCS_RST_WORD;
              d.diff = 48'h0;
              d.a_end = 1'b0;
              d.b_end = 1'b0;
              d.scan = 1'b0;
              d.done = 1'b0;
              d.pa = 8'h00;
              d.pb = 8'h00;
            end
          end
        end
        `MSCS_OFF_ABASE: d.abase = pwdata;
        `MSCS_OFF_ALEN: d.alen = pwdata;
        `MSCS_OFF_BBASE: d.bbase = pwdata;
        `MSCS_OFF_BLEN: d.blen = pwdata;
        `MSCS_OFF_CBASE: d.cbase = pwdata;
        `MSCS_OFF_IDXA: d.idx_a = pwdata;
        `MSCS_OFF_IDXB: d.idx_b = pwdata;
        `MSCS_OFF_THRLO: d.thr[31:0] = pwdata;
        `MSCS_OFF_THRHI: d.thr[47:32] = pwdata[15:0];
        `MSCS_OFF_DFLO: d.dflag[31:0] = pwdata;
        `MSCS_OFF_DFHI: d.dflag[63:32] = pwdata;
        default: d.prdata = d.prdata;
      endcase
    end
    unique case (q.st)
      st_idle: d.req = 1'b0;
      st_rd_a: begin
        if (a_done) begin
          d.ra = {56'h0, `MSCS_BLANK};
          d.st = st_rd_b;
        end else if (!q.req) begin
          d.req = 1'b1;
          d.addr = a_addr;
        end else if (mem_ack) begin
          d.req = 1'b0;
          d.ra = mem_rdata;
          d.st = st_rd_b;
        end
      end
      st_rd_b: begin
        if (b_done) begin
          d.rb = {56'h0, `MSCS_BLANK};
          d.st = st_rd_c;
        end else if (!q.req) begin
          d.req = 1'b1;
          d.addr = b_addr;
        end else if (mem_ack) begin
          d.req = 1'b0;
          d.rb = mem_rdata;
          d.st = st_rd_c;
        end
      end
      st_rd_c: begin
        if (q.mask_off | q.scan) begin
          d.st = st_eval;
        end else if (!q.req) begin
          d.req = 1'b1;
          d.addr = c_addr;
        end else if (mem_ack) begin
          d.req = 1'b0;
          d.rc = mem_rdata;
          d.st = st_eval;
        end
      end
      st_eval: begin
        d.st = st_rd_a;
        if (srch) begin
          if (cif.neq && diffn > q.thr) begin
            if (q.k == q.alen - q.blen) begin
              d.dflag[`MSCS_DF_NOSEL] = 1'b1;
              d.idx_a = q.a0 + q.alen;
              d.st = st_idle;
              d.fin = 1'b1;
              d.done = 1'b1;
            end else begin
              d.k = q.k + 32'h0000_0001;
              d.cnt = `MSCS_RST_WORD;
              d.diff = 48'h0;
            end
          end else if (q.cnt + 32'h0000_0001 == q.blen) begin
            d.idx_a = q.a0 + q.k;
            d.st = st_idle;
            d.fin = 1'b1;
            d.done = 1'b1;
          end else begin
            d.cnt = q.cnt + 32'h0000_0001;
            d.diff = diffn;
          end
        end else begin
          if (!q.a_end && q.lt == lt_delim8) begin
            del_a = q.ra[7:0] == q.alen[7:0];
          end else if (!q.a_end && q.lt == lt_delim16) begin
            del_a = q.cnt != 0 && {q.pa, q.ra[7:0]} == q.alen[15:0];
          end
          if (!q.b_end && q.lt == lt_delim8) begin
            del_b = q.rb[7:0] == q.blen[7:0];
          end else if (!q.b_end && q.lt == lt_delim16) begin
            del_b = q.cnt != 0 && {q.pb, q.rb[7:0]} == q.blen[15:0];
          end
          d.pa = q.ra[7:0];
          d.pb = q.rb[7:0];
          if (del_a) begin
            d.a_end = 1'b1;
            if (!q.noinc_a) d.idx_a = q.a0 + q.cnt + 32'h0000_0001;
          end
          if (del_b) begin
            d.b_end = 1'b1;
            if (!q.noinc_b) d.idx_b = q.b0 + q.cnt + 32'h0000_0001;
          end
          if (q.scan | del_a | del_b) begin
            d.scan = 1'b1;
            if ((q.a_end | del_a) & (q.b_end | del_b)) begin
              d.dflag[`MSCS_DF_LT:`MSCS_DF_EQ] = `MSCS_RES_EQ;
              d.st = st_idle;
              d.fin = 1'b1;
              d.done = 1'b1;
            end else begin
              d.cnt = q.cnt + 32'h0000_0001;
            end
          end else if (a_done & b_done) begin
            if (!q.noinc_a) d.idx_a = q.a0 + q.alen;
            if (!q.noinc_b) d.idx_b = q.b0 + q.blen;
            d.dflag[`MSCS_DF_LT:`MSCS_DF_EQ] = `MSCS_RES_EQ;
            d.st = st_idle;
            d.fin = 1'b1;
            d.done = 1'b1;
          end else if (cif.neq) begin
            if (!q.noinc_a) d.idx_a = q.a0 + q.cnt;
            if (!q.noinc_b) d.idx_b = q.b0 + q.cnt;
            d.dflag[`MSCS_DF_LT:`MSCS_DF_EQ] = cif.gt ?
              `MSCS_RES_GT : `MSCS_RES_LT;
            d.st = st_idle;
            d.fin = 1'b1;
            d.done = 1'b1;
          end else begin
            d.cnt = q.cnt + 32'h0000_0001;
          end
        end
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      q <= rst_v;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign mem_req = q.req;
  assign mem_addr = q.addr;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  flag_onehot_a: assert property (
    q.fin && !srch |-> $onehot(q.dflag[`MSCS_DF_LT:`MSCS_DF_EQ]))
    else $error("compare result flags not one-hot");
  hold_idx_a_a: assert property (
    q.fin && !srch && q.noinc_a |-> q.idx_a == q.a0)
    else $error("frozen first index moved");
  hold_idx_b_a: assert property (
    q.fin && !srch && q.noinc_b |-> q.idx_b == q.b0)
    else $error("frozen second index moved");
  part_inc_a: assert property (
    q.fin && !srch && !q.dflag[`MSCS_DF_EQ] && !q.noinc_b
    |-> q.idx_b == q.b0 + q.cnt)
    else $error("partial increment wrong");
  full_inc_a: assert property (
    q.fin && !srch && q.dflag[`MSCS_DF_EQ] && q.lt == lt_length &&
    !q.noinc_a |-> q.idx_a == q.a0 + q.alen)
    else $error("full increment wrong");
  delim_scan_a: assert property (
    q.fin && !srch && q.lt != lt_length && q.dflag[`MSCS_DF_EQ]
    |-> q.a_end && q.b_end)
    else $error("delimited compare ended before both delimiters");
  search_idx_a: assert property (
    q.fin && srch |-> (!q.dflag[`MSCS_DF_NOSEL] && q.idx_a == q.a0 + q.k) ||
    (q.dflag[`MSCS_DF_NOSEL] && q.idx_a == q.a0 + q.alen))
    else $error("search index wrong");
  attempt_bound_a: assert property (
    q.st != st_idle && srch |-> q.k <= q.alen - q.blen)
    else $error("too many search attempts");
  mask_addr_a: assert property (
    q.st == st_rd_c && q.req |-> q.addr == q.cbase + (q.cnt << sh))
    else $error("mask not aligned with key");
  mask_gen_a: assert property (
    q.mask_off |-> !(q.st == st_rd_c && q.req))
    else $error("mask fetched while generated");
  diff_reset_a: assert property (
    q.k != $past(q.k) |-> q.diff == 48'h0 && q.cnt == 0)
    else $error("difference count not restarted");
  word_step_a: assert property (
    word && q.req && q.st == st_rd_a |-> (q.addr - q.abase) % 8 == 0)
    else $error("word search off word boundary");
  pad_blank_a: assert property (
    q.st == st_rd_a && q.req |=> !q.a_end)
    else $error("exhausted field fetched");
endmodule

// file: mscs_mem_model.sv
// Memory model on the engine's read port, holding the operand fields.
// Assumes the bench fills mem by hierarchy and sets word_mode and slow.
`timescale 1ns/1ps
module mscs_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Read port
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic [63:0] mem_rdata,
  output logic mem_ack,
  // Mode and pace
  input wire logic word_mode,
  input wire logic slow
);
  logic [7:0] mem [0:4095];
  int unsigned wait_q;

  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
  end

  function automatic logic [63:0] word_at(logic [11:0] x);
    for (int i = 0; i < 8; i++) word_at[8*i+:8] = mem[x + 12'(i)];
  endfunction

  // ****
  // Answer one read, promptly or late
  // ****
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!rstn) begin
      wait_q <= 0;
      mem_rdata <= 64'h5555_5555_5555_5555;
    end else if (mem_req && !mem_ack) begin
      if (wait_q == 0) begin
        mem_ack <= 1'b1;
        mem_rdata <= word_mode ? word_at(mem_addr[11:0]) :
          {56'h0, mem[mem_addr[11:0]]};
        wait_q <= slow ? $urandom_range(3, 0) : 0;
      end else begin
        wait_q <= wait_q - 1;
      end
    end
  end
endmodule

// file: mscs_engine_bench.sv
// Self-checking bench for the masked compare and search engine.
// Assumes the design files and mscs_mem_model are compiled first.
`timescale 1ns/1ps
`include "mscs_consts.svh"
module mscs_engine_bench;
  import mscs_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, mem_req, mem_ack;
  logic [31:0] mem_addr;
  logic [63:0] mem_rdata;
  logic word_mode = 1'b0;
  logic slow = 1'b0;
  int err_count = 0;
  int checks = 0;
  localparam int AB = 'h100, BB = 'h300, CB = 'h500;

  always #4 clk = ~clk;

  mscs_engine dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  mscs_mem_model u_mem (.clk(clk), .rstn(rstn), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .word_mode(word_mode), .slow(slow));

  // ****
  // Checking and bus tasks
  // ****
  task automatic conclude();
    $display("errors %0d, checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= 32'(a);
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(nm, x, r);
  endtask

  // ****
  // Memory helpers and operation start
  // ****
  function automatic void put_el(int base, int idx, bit w, logic [63:0] v);
    for (int i = 0; i < (w ? 8 : 1); i++)
      u_mem.mem[base + (w ? idx * 8 : idx) + i] = v[8*i+:8];
  endfunction

  function automatic logic [63:0] get_el(int base, int idx, bit w);
    get_el = 64'h0;
    for (int i = 0; i < (w ? 8 : 1); i++)
      get_el[8*i+:8] = u_mem.mem[base + (w ? idx * 8 : idx) + i];
  endfunction

  function automatic logic [63:0] rnd(bit w, bit msk);
    logic [7:0] b;
    if (msk)
      b = ($urandom_range(3, 0) == 0) ? 8'h0f : 8'hff;
    else
      b = ($urandom_range(2, 0) == 0) ? 8'h20 : 8'(8'h41 + $urandom_range(2, 0));
    return w ? 64'(b) * 64'h0101_0101_0101_0101 : 64'(b);
  endfunction

  task automatic setup(int al, int bl, int ia, int ib, logic [47:0] thr);
    wr(`MSCS_OFF_ABASE, AB);
    wr(`MSCS_OFF_ALEN, al);
    wr(`MSCS_OFF_BBASE, BB);
    wr(`MSCS_OFF_BLEN, bl);
    wr(`MSCS_OFF_CBASE, CB);
    wr(`MSCS_OFF_IDXA, ia);
    wr(`MSCS_OFF_IDXB, ib);
    wr(`MSCS_OFF_THRLO, thr[31:0]);
    wr(`MSCS_OFF_THRHI, 32'(thr[47:32]));
    wr(`MSCS_OFF_DFLO, 32'h0000_0000);
    wr(`MSCS_OFF_DFHI, 32'h0000_0000);
  endtask

  task automatic run_op(int op, int lt, bit na, bit nb, bit mo);
    logic [31:0] s;
    logic e;
    int n;
    wr(`MSCS_OFF_CTRL, 32'h1 | (op << 1) | (lt << 3) | (na << 5) | (nb << 6)
      | (mo << 7));
    n = 0;
    do begin
      apb(1'b0, `MSCS_OFF_STATUS, 32'h0000_0000, s, e);
      n++;
    end while (s[0] !== 1'b0 && n < 500);
    chk("status", 32'h0000_0002, s);
  endtask

  // ****
  // Masked field compare against the model
  // ****
  task automatic cmp_test();
    int la, lb, n, ia, ib, pos, xa, xb, lt;
    bit mo, na, nb;
    logic [7:0] ca, cb, m;
    logic [2:0] res;
    lt = $urandom_range(2, 0);
    mo = $urandom_range(1, 0);
    na = $urandom_range(1, 0);
    nb = $urandom_range(1, 0);
    ia = $urandom_range(3, 0);
    ib = $urandom_range(3, 0);
    la = $urandom_range(6, 1);
    lb = lt ? la : $urandom_range(6, 1);
    n = la > lb ? la : lb;
    for (int i = 0; i < n; i++) begin
      put_el(AB, ia + i, 0, rnd(0, 0));
      put_el(BB, ib + i, 0, $urandom_range(3, 0) ? get_el(AB, ia + i, 0) :
        rnd(0, 0));
      put_el(CB, i, 0, rnd(0, 1));
    end
    put_el(AB, ia + n, 0, lt == 2 ? 64'hdd : 64'hff);
    put_el(BB, ib + n, 0, lt == 2 ? 64'hdd : 64'hee);
    put_el(AB, ia + n + 1, 0, 64'hff);
    put_el(BB, ib + n + 1, 0, 64'hee);
    res = `MSCS_RES_EQ;
    pos = -1;
    for (int i = 0; i < n && pos < 0; i++) begin
      ca = (i < la) ? 8'(get_el(AB, ia + i, 0)) : `MSCS_BLANK;
      cb = (i < lb) ? 8'(get_el(BB, ib + i, 0)) : `MSCS_BLANK;
      m = mo ? 8'hff : 8'(get_el(CB, i, 0));
      if (((ca ^ cb) & m) != 8'h00) begin
        pos = i;
        res = ((ca & m) > (cb & m)) ? `MSCS_RES_GT : `MSCS_RES_LT;
      end
    end
    xa = pos >= 0 ? pos : (lt ? n + lt : la);
    xb = pos >= 0 ? pos : (lt ? n + lt : lb);
    setup(lt ? (lt == 2 ? 'hddff : 'hff) : la,
      lt ? (lt == 2 ? 'hddee : 'hee) : lb, ia, ib, 48'h0);
    run_op(0, lt, na, nb, mo);
    rdchk("index a", `MSCS_OFF_IDXA, na ? ia : ia + xa);
    rdchk("index b", `MSCS_OFF_IDXB, nb ? ib : ib + xb);
    rdchk("flags hi", `MSCS_OFF_DFHI, 32'(res) << 21);
    rdchk("flags lo", `MSCS_OFF_DFLO, 32'h0000_0000);
  endtask

  // ****
  // Masked key search against the model
  // ****
  task automatic search_test();
    int la, lb, ia, ib, s0, s, d;
    bit w, mo, hit;
    logic [47:0] thr;
    logic [63:0] m;
    w = $urandom_range(1, 0);
    mo = $urandom_range(1, 0);
    ia = $urandom_range(3, 0);
    ib = $urandom_range(3, 0);
    la = $urandom_range(8, 3);
    lb = $urandom_range(3, 1);
    s0 = $urandom_range(la - lb, 0);
    thr = ($urandom_range(4, 0) == 4) ? 48'h1_0000_0000 : $urandom_range(2, 0);
    for (int i = 0; i < la; i++) put_el(AB, ia + i, w, rnd(w, 0));
    for (int k = 0; k < lb; k++) begin
      put_el(BB, ib + k, w, $urandom_range(2, 0) ?
        get_el(AB, ia + s0 + k, w) : rnd(w, 0));
      put_el(CB, k, w, rnd(w, 1));
    end
    hit = 0;
    s = 0;
    while (!hit && s <= la - lb) begin
      d = 0;
      for (int k = 0; k < lb; k++) begin
        m = mo ? (w ? '1 : 64'hff) : get_el(CB, k, w);
        if (((get_el(AB, ia + s + k, w) ^ get_el(BB, ib + k, w)) & m) != 0)
          d++;
      end
      if (48'(d) <= thr)
        hit = 1;
      else
        s++;
    end
    setup(la, lb, ia, ib, thr);
    word_mode <= w;
    run_op(w ? 2 : 1, 0, $urandom_range(1, 0), $urandom_range(1, 0), mo);
    rdchk("index a", `MSCS_OFF_IDXA, ia + (hit ? s : la));
    rdchk("index b", `MSCS_OFF_IDXB, ib);
    rdchk("flags hi", `MSCS_OFF_DFHI, hit ? 32'h0 : 32'h20);
  endtask

  // ****
  // Main sequence and watchdog
  // ****
  initial begin
    logic [31:0] r;
    logic e;
    void'($urandom(32'hec5d));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdchk("status", `MSCS_OFF_STATUS, `MSCS_RST_WORD);
    rdchk("flags hi", `MSCS_OFF_DFHI, `MSCS_RST_WORD);
    rdchk("index a", `MSCS_OFF_IDXA, `MSCS_RST_WORD);
    apb(1'b0, 8'h34, 32'h0000_0000, r, e);
    chk("unmapped error", 32'h0000_0001, 32'(e));
    chk("unmapped data", 32'h0000_0000, r);
    wr(`MSCS_OFF_CTRL, 32'h0000_0007);
    rdchk("status", `MSCS_OFF_STATUS, `MSCS_RST_WORD);
    for (int t = 0; t < 40; t++) begin
      slow <= $urandom_range(1, 0);
      cmp_test();
    end
    for (int t = 0; t < 40; t++) begin
      slow <= $urandom_range(1, 0);
      search_test();
    end
    conclude();
  end

  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    $display("unexpected run length: expected end, seen timeout");
    conclude();
  end
endmodule
